// ==== rtl/sl_pkg.sv ====
// shared constants and state types for the status indicator block
package sl_pkg;

    // apb map, byte addresses, one aligned word each
    localparam int ADDR_W = 12;
    localparam logic [11:0] HARDWARE_CONFIG_REG_OFS = 12'h000;
    localparam logic [11:0] ASIC_CONFIG_OFS = 12'h004;
    localparam logic [11:0] POWER_MGMT_CONTROL_REG_OFS = 12'h008;
    localparam logic [11:0] RUN_OVERRIDE_OFS = 12'h00C;
    localparam logic [11:0] ERR_OVERRIDE_OFS = 12'h010;
    localparam logic [11:0] STATUS_OFS = 12'h014;

    // pin order in every indicator vector: links 0..2, run, error
    localparam int NUM_PINS = 5;
    localparam int NUM_PORTS = 3;
    localparam int RUN_IDX = 3;
    localparam int ERR_IDX = 4;

    // field positions
    localparam int POL_LSB = 0;
    localparam int SHIFT_LSB = 8;
    localparam int ERR_EN_BIT = 0;
    localparam int STATE_MODE_BIT = 1;
    localparam int DISABLE_BIT = 0;
    localparam int OVR_EN_BIT = 0;
    localparam int OVR_VAL_BIT = 1;
    localparam int LIT_LSB = 0;
    localparam int EE_ERR_BIT = 8;

    // reset values
    localparam logic [4:0] POL_RST = 5'h00;
    localparam logic [1:0] OVR_RST = 2'h0;
    localparam logic [1:0] SHIFT_RST = 2'h0;

    // transmit shift timing
    localparam int CLK_PERIOD_NS = 10;
    localparam int TX_STEP_NS = 10;
    localparam int TX_STEP_CYC = (TX_STEP_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int TX_STEPS = 3;
    localparam int TX_W = 5;
    localparam logic [1:0] TX_SHIFT_BASE = 2'h2;

    typedef enum logic {PH_STRAP, PH_RUN} phase_e;

    typedef struct packed {
        phase_e phase;
        logic [4:0] pol;
        logic err_en;
        logic state_mode;
        logic dis;
        logic [1:0] run_ovr;
        logic [1:0] err_ovr;
        logic [1:0] shift;
        logic [31:0] rdata;
        logic [4:0] pin_out;
        logic [4:0] pin_oe;
    } ctrl_s;

    localparam ctrl_s CTRL_RST = '{phase: PH_STRAP, pol: POL_RST, err_en: 1'b0,
        state_mode: 1'b0, dis: 1'b0, run_ovr: OVR_RST, err_ovr: OVR_RST,
        shift: SHIFT_RST, rdata: 32'h0000_0000, pin_out: 5'h00, pin_oe: 5'h00};

endpackage

// ==== rtl/tx_shift_line.sv ====
// selectable whole-cycle delay line for transmit data and enable
`timescale 1ns/1ps
module tx_shift_line #(
    parameter int W = sl_pkg::TX_W,
    parameter int STEPS = sl_pkg::TX_STEPS,
    parameter int STEP_CYC = sl_pkg::TX_STEP_CYC
) (
    input wire logic clk,
    input wire logic rst,
    input wire logic [1:0] steps,
    input wire logic [W-1:0] din,
    output logic [W-1:0] dout
);
    localparam int DEPTH = STEPS * STEP_CYC;

    typedef struct packed {
        logic [DEPTH-1:0][W-1:0] pipe;
        logic [W-1:0] dout;
    } line_s;

    line_s q;
    line_s d;

    // the output flop adds one fixed cycle to every setting
    always_comb begin
        d = q;
        d.pipe[0] = din;
        for (int i = 1; i < DEPTH; i++) begin
            d.pipe[i] = q.pipe[i-1];
        end
        if (steps == 2'h0) begin
            d.dout = din;
        end else begin
            d.dout = q.pipe[int'(steps) * STEP_CYC - 1];
        end
    end

    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            q <= '0;
        end else begin
            q <= d;
        end
    end

    assign dout = q.dout;

    // zero added delay still passes through the output flop
    no_shift_a: assert property (@(posedge clk) disable iff (rst)
        !$past(rst) && $past(steps) == 2'h0 |-> dout == $past(din))
        else $error("zero shift setting not one cycle");

endmodule

// ==== rtl/status_led_control.sv ====
// indicator pin control, strap capture, transmit shift and apb registers
//
// Local design decisions: the APB slave port and the register offsets.
`timescale 1ns/1ps
module status_led_control (
    input wire logic SYS_CLK,
    input wire logic RST,
    input wire logic PSEL,
    input wire logic PENABLE,
    input wire logic PWRITE,
    input wire logic [11:0] PADDR,
    input wire logic [31:0] PWDATA,
    output logic [31:0] PRDATA,
    output logic PREADY,
    output logic PSLVERR,
    input wire logic CORE_RUN_STATE,
    input wire logic CORE_ERR_STATE,
    input wire logic [2:0] PORT_LINK_ACT,
    input wire logic EEPROM_LOAD_ERR,
    input wire logic CFG_LOAD_STB,
    input wire logic [1:0] CFG_LOAD_DATA,
    input wire logic [4:0] INDICATOR_POLARITY_STRAPS,
    input wire logic [4:0] STRAP_ON_PIN,
    input wire logic [4:0] STRAP_PIN_VAL,
    input wire logic [1:0] TX_SHIFT_STRAPS,
    input wire logic [3:0] TXD_IN,
    input wire logic TXEN_IN,
    output logic [3:0] TXD_OUT,
    output logic TXEN_OUT,
    output logic RUN_INDICATOR_OUT,
    output logic RUN_INDICATOR_OE,
    output logic ERROR_INDICATOR_OUT,
    output logic ERROR_INDICATOR_OE,
    output logic [2:0] LINK_ACTIVITY_INDICATOR_OUT,
    output logic [2:0] LINK_ACTIVITY_INDICATOR_OE
);

    sl_pkg::ctrl_s q;
    sl_pkg::ctrl_s d;
    logic setup;
    logic access;
    logic hit;
    logic [31:0] rd;
    logic run_src;
    logic err_src;
    logic err_allow;
    logic err_on;
    logic run_on;
    logic [4:0] lit;
    logic [4:0] tx_out;

    // whole next state in one process
    always_comb begin
        d = q;
        setup = PSEL && !PENABLE;
        access = PSEL && PENABLE;
        hit = 1'b1;
        rd = '0;

        // straps are caught one edge after reset release, never under reset
        if (q.phase == sl_pkg::PH_STRAP) begin
            d.phase = sl_pkg::PH_RUN;
            // strap-shared pins take the inverse so the pull sets the idle level
            d.pol = (STRAP_ON_PIN & ~STRAP_PIN_VAL)
                | (~STRAP_ON_PIN & INDICATOR_POLARITY_STRAPS);
            d.shift = TX_SHIFT_STRAPS;
        end

        // configuration memory image of the asic word
        if (CFG_LOAD_STB) begin
            d.err_en = CFG_LOAD_DATA[sl_pkg::ERR_EN_BIT];
            d.state_mode = CFG_LOAD_DATA[sl_pkg::STATE_MODE_BIT];
        end

        // read mux; an unmapped address reads zero and errors
        case (PADDR)
            sl_pkg::HARDWARE_CONFIG_REG_OFS: begin
                rd[sl_pkg::POL_LSB +: sl_pkg::NUM_PINS] = q.pol;
                rd[sl_pkg::SHIFT_LSB +: 2] = q.shift;
            end
            sl_pkg::ASIC_CONFIG_OFS: begin
                rd[sl_pkg::ERR_EN_BIT] = q.err_en;
                rd[sl_pkg::STATE_MODE_BIT] = q.state_mode;
            end
            sl_pkg::POWER_MGMT_CONTROL_REG_OFS: begin
                rd[sl_pkg::DISABLE_BIT] = q.dis;
            end
            sl_pkg::RUN_OVERRIDE_OFS: begin
                rd[1:0] = q.run_ovr;
            end
            sl_pkg::ERR_OVERRIDE_OFS: begin
                rd[1:0] = q.err_ovr;
            end
            sl_pkg::STATUS_OFS: begin
                rd[sl_pkg::LIT_LSB +: sl_pkg::NUM_PINS] = q.pin_oe;
                rd[sl_pkg::EE_ERR_BIT] = EEPROM_LOAD_ERR;
            end
            default: begin
                hit = 1'b0;
            end
        endcase

        // read data is caught in setup so it stands through the access phase
        if (setup) begin
            d.rdata = rd;
        end

        // a write wins over a same-cycle memory load, software had the last word
        if (access && PWRITE) begin
            case (PADDR)
                sl_pkg::HARDWARE_CONFIG_REG_OFS: begin
                    d.pol = PWDATA[sl_pkg::POL_LSB +: sl_pkg::NUM_PINS];
                end
                sl_pkg::ASIC_CONFIG_OFS: begin
                    d.err_en = PWDATA[sl_pkg::ERR_EN_BIT];
                    d.state_mode = PWDATA[sl_pkg::STATE_MODE_BIT];
                end
                sl_pkg::POWER_MGMT_CONTROL_REG_OFS: begin
                    d.dis = PWDATA[sl_pkg::DISABLE_BIT];
                end
                sl_pkg::RUN_OVERRIDE_OFS: begin
                    d.run_ovr = PWDATA[1:0];
                end
                sl_pkg::ERR_OVERRIDE_OFS: begin
                    d.err_ovr = PWDATA[1:0];
                end
                default: begin
                    d.rdata = q.rdata;
                end
            endcase
        end

        // indicator sources, override replaces the core state
        run_src = q.run_ovr[sl_pkg::OVR_EN_BIT] ? q.run_ovr[sl_pkg::OVR_VAL_BIT]
            : CORE_RUN_STATE;
        err_src = q.err_ovr[sl_pkg::OVR_EN_BIT] ? q.err_ovr[sl_pkg::OVR_VAL_BIT]
            : CORE_ERR_STATE;

        // forced enable only for an active-low error pin, whose high strap is safe
        err_allow = q.err_en
            || (EEPROM_LOAD_ERR && !q.pol[sl_pkg::ERR_IDX]);
        err_on = err_src && err_allow;

        // a bi-colour part must never show both colours at once
        run_on = run_src && !(q.state_mode && err_on);

        // link pins follow the port number whatever the chip mode
        lit = {err_on, run_on, PORT_LINK_ACT};

        // enable carries the on state; the data pin just holds the active level
        d.pin_out = q.pol;
        if (q.phase == sl_pkg::PH_RUN && !q.dis) begin
            d.pin_oe = lit;
        end else begin
            d.pin_oe = '0;
        end
    end

    // single state register
    always_ff @(posedge SYS_CLK or posedge RST) begin
        if (RST) begin
            q <= sl_pkg::CTRL_RST;
        end else begin
            q <= d;
        end
    end

    // bus answers in the first access cycle, no wait states
    assign PREADY = 1'b1;
    assign PSLVERR = PSEL && PENABLE && !hit;
    assign PRDATA = q.rdata;

    // pin outputs straight from flops
    assign RUN_INDICATOR_OUT = q.pin_out[sl_pkg::RUN_IDX];
    assign RUN_INDICATOR_OE = q.pin_oe[sl_pkg::RUN_IDX];
    assign ERROR_INDICATOR_OUT = q.pin_out[sl_pkg::ERR_IDX];
    assign ERROR_INDICATOR_OE = q.pin_oe[sl_pkg::ERR_IDX];
    assign LINK_ACTIVITY_INDICATOR_OUT = q.pin_out[sl_pkg::NUM_PORTS-1:0];
    assign LINK_ACTIVITY_INDICATOR_OE = q.pin_oe[sl_pkg::NUM_PORTS-1:0];

    // setting 2 is the zero point, xor turns the order 2,3,0,1 into 0..3 steps
    tx_shift_line #(
        .W(sl_pkg::TX_W),
        .STEPS(sl_pkg::TX_STEPS),
        .STEP_CYC(sl_pkg::TX_STEP_CYC)
    ) u_tx_shift (
        .clk(SYS_CLK),
        .rst(RST),
        .steps(q.shift ^ sl_pkg::TX_SHIFT_BASE),
        .din({TXEN_IN, TXD_IN}),
        .dout(tx_out)
    );

    assign TXD_OUT = tx_out[3:0];
    assign TXEN_OUT = tx_out[4];

    // helper: age after reset, so history checks skip reset-time samples
    logic [2:0] age_q;
    logic warm;
    logic [4:0] oe_all;
    logic [4:0] out_all;

    always_ff @(posedge SYS_CLK or posedge RST) begin
        if (RST) begin
            age_q <= 3'h0;
        end else if (age_q != 3'h7) begin
            age_q <= age_q + 3'h1;
        end
    end

    assign warm = (age_q == 3'h7);
    assign oe_all = {ERROR_INDICATOR_OE, RUN_INDICATOR_OE, LINK_ACTIVITY_INDICATOR_OE};
    assign out_all = {ERROR_INDICATOR_OUT, RUN_INDICATOR_OUT, LINK_ACTIVITY_INDICATOR_OUT};

    default clocking cb @(posedge SYS_CLK);
    endclocking
    default disable iff (RST);

    // sampled reset keeps the release edge out, the field is still at reset there
    sequence strap_phase;
        !RST && q.phase == sl_pkg::PH_STRAP;
    endsequence

    sequence pol_write;
        access && PWRITE && PADDR == sl_pkg::HARDWARE_CONFIG_REG_OFS;
    endsequence

    sequence ee_force;
        EEPROM_LOAD_ERR && !q.pol[sl_pkg::ERR_IDX] && !q.err_en && !q.dis
            && q.phase == sl_pkg::PH_RUN;
    endsequence

    // link pins map one to one onto ports
    link_fixed_a: assert property (
        q.phase == sl_pkg::PH_RUN && !q.dis
        |=> LINK_ACTIVITY_INDICATOR_OE == $past(PORT_LINK_ACT))
        else $error("link pin does not follow its port");

    // a driven pin sits at the configured active level
    level_select_a: assert property (
        warm |-> (oe_all & (out_all ^ $past(q.pol))) == 5'h00)
        else $error("driven pin not at polarity level");

    // software write lands in the polarity field
    pol_written_a: assert property (
        pol_write |=> q.pol == $past(PWDATA[4:0]))
        else $error("polarity write lost");

    // plain straps load the field default
    strap_default_a: assert property (
        strap_phase |=> ((q.pol ^ $past(INDICATOR_POLARITY_STRAPS))
            & ~$past(STRAP_ON_PIN)) == 5'h00)
        else $error("polarity default not from straps");

    // shared pins take the inverted strap
    strap_inverse_a: assert property (
        strap_phase |=> ((q.pol ^ ~$past(STRAP_PIN_VAL)) & $past(STRAP_ON_PIN)) == 5'h00)
        else $error("shared pin default not inverted");

    // nothing is driven that is not lit
    idle_undriven_a: assert property (
        warm |-> (oe_all & ~$past(lit)) == 5'h00)
        else $error("pin driven while off");

    // error pin stays quiet without its enable
    err_enable_a: assert property (
        !q.err_en && !(EEPROM_LOAD_ERR && !q.pol[sl_pkg::ERR_IDX]) |=> !ERROR_INDICATOR_OE)
        else $error("error pin driven while disabled");

    // load error with an active-low pin forces the pin live
    forced_err_a: assert property (
        ee_force ##0 (q.err_ovr[0] ? q.err_ovr[1] : CORE_ERR_STATE) |=> ERROR_INDICATOR_OE)
        else $error("load error did not force error pin");

    // run override drives the run pin on
    run_override_a: assert property (
        q.run_ovr == 2'h3 && !q.dis && !q.state_mode && q.phase == sl_pkg::PH_RUN
        |=> RUN_INDICATOR_OE)
        else $error("run override ignored");

    // error override can hold the error pin off
    err_override_a: assert property (
        q.err_ovr == 2'h1 |=> !ERROR_INDICATOR_OE)
        else $error("error override ignored");

    // bi-colour never lit twice
    bicolour_excl_a: assert property (
        warm && $past(q.state_mode) && ERROR_INDICATOR_OE |-> !RUN_INDICATOR_OE)
        else $error("both colours lit in state mode");

    // memory load sets the state mode bit
    mode_load_a: assert property (
        CFG_LOAD_STB && !(access && PWRITE && PADDR == sl_pkg::ASIC_CONFIG_OFS)
        |=> q.state_mode == $past(CFG_LOAD_DATA[1]))
        else $error("state mode not loaded");

    // disable silences every pin over all other causes
    disable_wins_a: assert property (
        q.dis |=> oe_all == 5'h00)
        else $error("pin driven while disabled");

    // setting 2 adds nothing beyond the output flop
    shift_zero_a: assert property (
        warm && $past(q.shift) == 2'h2 |-> tx_out == $past({TXEN_IN, TXD_IN}))
        else $error("shift 2 not minimal");

    // setting 1 adds the full three steps
    shift_max_a: assert property (
        warm && $past(q.shift) == 2'h1 |-> tx_out == $past({TXEN_IN, TXD_IN}, 4))
        else $error("shift 1 not three steps");

    // setting 3 adds one step
    shift_one_a: assert property (
        warm && $past(q.shift) == 2'h3 |-> tx_out == $past({TXEN_IN, TXD_IN}, 2))
        else $error("shift 3 not one step");

    // setting 0 adds two steps
    shift_two_a: assert property (
        warm && $past(q.shift) == 2'h0 |-> tx_out == $past({TXEN_IN, TXD_IN}, 3))
        else $error("shift 0 not two steps");

    // straps latch once, a later edge never reopens the capture
    strap_once_a: assert property (
        q.phase == sl_pkg::PH_RUN |=> q.phase == sl_pkg::PH_RUN)
        else $error("strap capture entered again");

    // the shift setting only ever comes from the straps
    shift_kept_a: assert property (
        q.phase == sl_pkg::PH_RUN |=> $stable(q.shift))
        else $error("shift setting changed after straps");

    // nothing is driven while the straps are being sampled
    strap_quiet_a: assert property (
        strap_phase |=> oe_all == 5'h00)
        else $error("pin driven during strap capture");

    // memory load also sets the error pin enable
    enable_load_a: assert property (
        CFG_LOAD_STB && !(access && PWRITE && PADDR == sl_pkg::ASIC_CONFIG_OFS)
        |=> q.err_en == $past(CFG_LOAD_DATA[0]))
        else $error("error enable not loaded");

endmodule

// ==== tb/led_board_model.sv ====
// indicator leds with their board pull resistors
`timescale 1ns/1ps
module led_board_model (
    input wire logic [4:0] pin_out,
    input wire logic [4:0] pin_oe,
    input wire logic [4:0] pull_lvl,
    output logic [4:0] lit
);
    logic [4:0] pin;
    // a released pin sits at its pull level, so its led stays dark
    assign pin = (pin_oe & pin_out) | (~pin_oe & pull_lvl);
    assign lit = pin ^ pull_lvl;
endmodule

// ==== tb/status_led_control_tb_top.sv ====
// self-checking bench for the status indicator block
`timescale 1ns/1ps
module status_led_control_tb_top;
    localparam logic [4:0] POL_EXP = 5'h16;
    logic SYS_CLK, RST, PSEL, PENABLE, PWRITE, PREADY, PSLVERR;
    logic [11:0] PADDR;
    logic [31:0] PWDATA, PRDATA, rdv;
    logic CORE_RUN_STATE, CORE_ERR_STATE, EEPROM_LOAD_ERR, CFG_LOAD_STB, TXEN_IN, TXEN_OUT;
    logic [2:0] PORT_LINK_ACT, LINK_ACTIVITY_INDICATOR_OUT, LINK_ACTIVITY_INDICATOR_OE;
    logic [1:0] CFG_LOAD_DATA, TX_SHIFT_STRAPS;
    logic [4:0] INDICATOR_POLARITY_STRAPS, STRAP_ON_PIN, STRAP_PIN_VAL, pin_out, pin_oe, lit;
    logic [3:0] TXD_IN, TXD_OUT;
    logic RUN_INDICATOR_OUT, RUN_INDICATOR_OE, ERROR_INDICATOR_OUT, ERROR_INDICATOR_OE, erv;
    int failures = 0;
    int n_checks = 0;
    int cycles = 0;

    status_led_control u_dut (.SYS_CLK, .RST, .PSEL, .PENABLE, .PWRITE, .PADDR, .PWDATA,
        .PRDATA, .PREADY, .PSLVERR, .CORE_RUN_STATE, .CORE_ERR_STATE, .PORT_LINK_ACT,
        .EEPROM_LOAD_ERR, .CFG_LOAD_STB, .CFG_LOAD_DATA, .INDICATOR_POLARITY_STRAPS,
        .STRAP_ON_PIN, .STRAP_PIN_VAL, .TX_SHIFT_STRAPS, .TXD_IN, .TXEN_IN, .TXD_OUT,
        .TXEN_OUT, .RUN_INDICATOR_OUT, .RUN_INDICATOR_OE, .ERROR_INDICATOR_OUT,
        .ERROR_INDICATOR_OE, .LINK_ACTIVITY_INDICATOR_OUT, .LINK_ACTIVITY_INDICATOR_OE);

    // pull resistors sit at the inactive level of the strapped polarity
    assign pin_out = {ERROR_INDICATOR_OUT, RUN_INDICATOR_OUT, LINK_ACTIVITY_INDICATOR_OUT};
    assign pin_oe = {ERROR_INDICATOR_OE, RUN_INDICATOR_OE, LINK_ACTIVITY_INDICATOR_OE};
    led_board_model u_board (.pin_out(pin_out), .pin_oe(pin_oe), .pull_lvl(~POL_EXP), .lit(lit));

    initial begin
        SYS_CLK = 1'b0;
        forever #5 SYS_CLK = ~SYS_CLK;
    end

    task automatic give_verdict;
        $display("checks %0d mismatches %0d", n_checks, failures);
        if (failures == 0 && n_checks > 0) begin
            $display("All tests passed");
        end else begin
            $display("Some tests failed");
        end
        $finish;
    endtask

    // hang guard, the whole run needs well under a thousand cycles
    always @(posedge SYS_CLK) begin
        cycles <= cycles + 1;
        if (cycles == 20000) begin
            failures++;
            give_verdict();
        end
    end

    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        n_checks++;
        if (seen !== exp) begin
            failures++;
            $display("unexpected at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask

    // step past the edge so the design's updates have landed
    task automatic tick(input int n);
        repeat (n) @(posedge SYS_CLK);
        #1;
    endtask

    // one apb transfer, request held until pready is seen at an edge
    task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] d);
        @(posedge SYS_CLK);
        PSEL <= 1'b1;
        PENABLE <= 1'b0;
        PWRITE <= wr;
        PADDR <= a;
        PWDATA <= d;
        @(posedge SYS_CLK);
        PENABLE <= 1'b1;
        do begin
            @(posedge SYS_CLK);
        end while (PREADY !== 1'b1);
        rdv = PRDATA;
        erv = PSLVERR;
        PSEL <= 1'b0;
        PENABLE <= 1'b0;
    endtask

    task automatic see_lit(input logic [4:0] e);
        tick(2);
        check({27'h0, lit}, {27'h0, e});
    endtask

    task automatic do_reset(input logic [1:0] s);
        @(posedge SYS_CLK);
        TX_SHIFT_STRAPS <= s;
        RST <= 1'b1;
        repeat (6) @(posedge SYS_CLK);
        RST <= 1'b0;
        tick(3);
    endtask

    task automatic t_map;
        apb(1'b0, sl_pkg::HARDWARE_CONFIG_REG_OFS, 32'h0);
        check(rdv, 32'h0000_0216);
        apb(1'b0, 12'h020, 32'h0);
        check({31'h0, erv}, 32'h1);
        $display("test map done");
    endtask

    task automatic t_links;
        @(posedge SYS_CLK);
        PORT_LINK_ACT <= 3'h5;
        see_lit(5'h05);
        @(posedge SYS_CLK);
        PORT_LINK_ACT <= 3'h2;
        see_lit(5'h02);
        $display("test links done");
    endtask

    // error pin enable, load from config memory, then bi-colour mode
    task automatic t_err;
        @(posedge SYS_CLK);
        PORT_LINK_ACT <= 3'h0;
        CORE_ERR_STATE <= 1'b1;
        see_lit(5'h00);
        @(posedge SYS_CLK);
        CFG_LOAD_STB <= 1'b1;
        CFG_LOAD_DATA <= 2'h3;
        @(posedge SYS_CLK);
        CFG_LOAD_STB <= 1'b0;
        see_lit(5'h10);
        apb(1'b0, sl_pkg::ASIC_CONFIG_OFS, 32'h0);
        check(rdv, 32'h3);
        @(posedge SYS_CLK);
        CORE_RUN_STATE <= 1'b1;
        apb(1'b1, sl_pkg::ASIC_CONFIG_OFS, 32'h3);
        see_lit(5'h10);
        apb(1'b1, sl_pkg::ASIC_CONFIG_OFS, 32'h1);
        see_lit(5'h18);
        $display("test error done");
    endtask

    task automatic t_ovr_dis;
        @(posedge SYS_CLK);
        CORE_RUN_STATE <= 1'b0;
        CORE_ERR_STATE <= 1'b0;
        apb(1'b1, sl_pkg::RUN_OVERRIDE_OFS, 32'h3);
        see_lit(5'h08);
        apb(1'b1, sl_pkg::ERR_OVERRIDE_OFS, 32'h3);
        see_lit(5'h18);
        // override value 0 must hold the error pin dark against the core
        @(posedge SYS_CLK);
        CORE_ERR_STATE <= 1'b1;
        apb(1'b1, sl_pkg::ERR_OVERRIDE_OFS, 32'h1);
        see_lit(5'h08);
        apb(1'b1, sl_pkg::ERR_OVERRIDE_OFS, 32'h3);
        @(posedge SYS_CLK);
        PORT_LINK_ACT <= 3'h7;
        apb(1'b1, sl_pkg::POWER_MGMT_CONTROL_REG_OFS, 32'h1);
        tick(2);
        check({27'h0, pin_oe}, 32'h0);
        apb(1'b1, sl_pkg::POWER_MGMT_CONTROL_REG_OFS, 32'h0);
        see_lit(5'h1F);
        $display("test override done");
    endtask

    // load failure forces the error pin only when it is active low
    task automatic t_load_err;
        apb(1'b1, sl_pkg::ERR_OVERRIDE_OFS, 32'h0);
        apb(1'b1, sl_pkg::ASIC_CONFIG_OFS, 32'h0);
        apb(1'b1, sl_pkg::HARDWARE_CONFIG_REG_OFS, 32'h6);
        @(posedge SYS_CLK);
        CORE_ERR_STATE <= 1'b1;
        EEPROM_LOAD_ERR <= 1'b1;
        tick(2);
        check({30'h0, ERROR_INDICATOR_OE, ERROR_INDICATOR_OUT}, 32'h2);
        apb(1'b1, sl_pkg::HARDWARE_CONFIG_REG_OFS, 32'h16);
        tick(2);
        check({31'h0, ERROR_INDICATOR_OE}, 32'h0);
        // status: links and run override driven, load error flag set
        apb(1'b0, sl_pkg::STATUS_OFS, 32'h0);
        check(rdv, 32'h0000_010F);
        $display("test load error done");
    endtask

    // each shift setting needs its own reset since straps latch once
    // settings 3 and 0 are the ones a back-to-back link would use
    task automatic t_tx;
        int s;
        int k;
        int got;
        for (s = 0; s < 4; s++) begin
            do_reset(s[1:0]);
            apb(1'b0, sl_pkg::HARDWARE_CONFIG_REG_OFS, 32'h0);
            check(rdv, 32'h16 | (32'(s) << 8));
            @(posedge SYS_CLK);
            TXEN_IN <= 1'b1;
            TXD_IN <= 4'hA;
            got = 0;
            for (k = 1; k <= 8 && got == 0; k++) begin
                tick(1);
                if (TXEN_OUT === 1'b1) got = k;
            end
            check(32'(got), 32'(1 + (s ^ 2)));
            check({28'h0, TXD_OUT}, 32'hA);
            @(posedge SYS_CLK);
            TXEN_IN <= 1'b0;
        end
        $display("test transmit shift done");
    endtask

    initial begin
        {PSEL, PENABLE, PWRITE, CORE_RUN_STATE, CORE_ERR_STATE} = 5'h00;
        {EEPROM_LOAD_ERR, CFG_LOAD_STB, TXEN_IN} = 3'h0;
        RST = 1'b1;
        PADDR = 12'h000;
        PWDATA = 32'h0;
        PORT_LINK_ACT = 3'h0;
        CFG_LOAD_DATA = 2'h0;
        TX_SHIFT_STRAPS = 2'h2;
        TXD_IN = 4'h0;
        INDICATOR_POLARITY_STRAPS = 5'h15;
        STRAP_ON_PIN = 5'h03;
        STRAP_PIN_VAL = 5'h01;
        do_reset(2'h2);
        t_map();
        t_links();
        t_err();
        t_ovr_dis();
        t_load_err();
        t_tx();
        give_verdict();
    end
endmodule
